// file: hdl/ccs_map.svh
`ifndef CCS_MAP_SVH
`define CCS_MAP_SVH

// status word bit positions
`define CCS_ST_AR_FULL 0
`define CCS_ST_CB_FULL 1
`define CCS_ST_INHIBIT 3
`define CCS_ST_CHANNEL_ACTIVE_FLAG 4
`define CCS_ST_CHAN_STROBE 5
`define CCS_ST_BAD_FUNC 9
`define CCS_ST_SD_FAULT 10
`define CCS_ST_CHANNEL_DATA_PARITY_FAULT 15
`define CCS_ST_CTRL_WORD_PARITY_FAULT 16
`define CCS_ST_NXM 17
`define CCS_ST_DRIVE_BUS_PARITY_FAULT 18
`define CCS_ST_DRV_ERR 19
`define CCS_ST_CHAN_SUM 20
`define CCS_ST_CW_WRITTEN 21
`define CCS_ST_OVERRUN 22
`define CCS_ST_DRE 23
`define CCS_ST_ILC 24
`define CCS_ST_SUPPLY 25
`define CCS_ST_CTRL_BUS_OVERRUN 28
`define CCS_ST_AF_EN 29
`define CCS_ST_ATTENTION_IRQ_ENABLE 30
`define CCS_ST_BUSY 31
`define CCS_ST_DONE 32
`define CCS_ST_PIA 33

// control word bit positions
`define CCS_CT_DRIVE_BUS_PARITY_FAULT_CLR 18
`define CCS_CT_EXC_CLR 19
`define CCS_CT_CHAN_CLR 20
`define CCS_CT_WRT_CW 21
`define CCS_CT_OVR_CLR 22
`define CCS_CT_DRE_CLR 23
`define CCS_CT_ILC_CLR 24
`define CCS_CT_RESET 25
`define CCS_CT_CTRL_BUS_OVERRUN_CLR 28
`define CCS_CT_AF_EN 29
`define CCS_CT_ATTENTION_IRQ_ENABLE 30
`define CCS_CT_STOP 31
`define CCS_CT_DONE_CLR 32
`define CCS_CT_PIA 33

// function codes accepted by the command register, octal 71 and 61
`define CCS_FUNC_READ 6'h39
`define CCS_FUNC_WRITE 6'h31

// reset values
`define CCS_PIA_RESET 3'h0

`endif

// file: hdl/ccs_pkg.sv
package ccs_pkg;
    typedef logic [35:0] ccs_word_t;
    typedef logic [5:0] ccs_func_t;
    typedef logic [2:0] ccs_pia_t;
    typedef enum logic [3:0] {
        CCS_IDLE = 4'b0001,
        CCS_XFER = 4'b0010,
        CCS_TERM = 4'b0100,
        CCS_DONE = 4'b1000
    } ccs_state_t;
endpackage

// file: hdl/ccs_err_if.sv
`timescale 1ns/1ps
interface ccs_err_if;
    logic [12:0] set;
    logic [12:0] clr;
    logic [12:0] flags;
    modport owner (input set, input clr, output flags);
    modport user (output set, output clr, input flags);
endinterface

// file: hdl/ccs_err_bank.sv
`timescale 1ns/1ps
module ccs_err_bank (
    input wire logic CLK,
    input wire logic RST,
    ccs_err_if.owner eb
);
    // ----------------------------------------
    // sticky error flags, set beats clear
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 13; gi = gi + 1) begin : g_flag
            logic flag_q;
            always_ff @(posedge CLK) begin
                if (RST) begin
                    flag_q <= 1'b0;
                end else if (eb.set[gi]) begin
                    flag_q <= 1'b1;
                end else if (eb.clr[gi]) begin
                    flag_q <= 1'b0;
                end
            end
            assign eb.flags[gi] = flag_q;
        end
    endgenerate
endmodule

// file: hdl/ccs_path.sv
`timescale 1ns/1ps
module ccs_path (
    input wire logic CLK,
    input wire logic RST,
    input wire logic write_mode,
    input wire logic flush,
    input wire logic chan_load,
    input wire logic [35:0] chan_word,
    input wire logic chan_take,
    input wire logic drive_load,
    input wire logic [35:0] drive_word,
    input wire logic db_take,
    output logic ar_full,
    output logic cb_full,
    output logic db_full,
    output logic [35:0] cb_q,
    output logic [35:0] db_q
);
    logic [35:0] ar_q;
    logic ar_full_q;
    logic cb_full_q;
    logic db_full_q;
    logic ar_to_db;
    logic ar_to_cb;
    logic cb_to_ar;

    assign ar_to_db = write_mode && ar_full_q && !db_full_q;
    assign ar_to_cb = !write_mode && ar_full_q && !cb_full_q;
    assign cb_to_ar = write_mode && cb_full_q && !ar_full_q;
    assign ar_full = ar_full_q;
    assign cb_full = cb_full_q;
    assign db_full = db_full_q;

    always_ff @(posedge CLK) begin
        if (RST || flush) begin
            ar_full_q <= 1'b0;
        end else if (cb_to_ar || (!write_mode && drive_load && !ar_full_q)) begin
            ar_full_q <= 1'b1;
        end else if (ar_to_db || ar_to_cb) begin
            ar_full_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (cb_to_ar) begin
            ar_q <= cb_q;
        end else if (!write_mode && drive_load && !ar_full_q) begin
            ar_q <= drive_word;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST || flush) begin
            cb_full_q <= 1'b0;
        end else if (ar_to_cb || (write_mode && chan_load && !cb_full_q)) begin
            cb_full_q <= 1'b1;
        end else if (cb_to_ar || (!write_mode && chan_take)) begin
            cb_full_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            cb_q <= 36'h0;
        end else if (ar_to_cb) begin
            cb_q <= ar_q;
        end else if (write_mode && chan_load && !cb_full_q) begin
            cb_q <= chan_word;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST || flush) begin
            db_full_q <= 1'b0;
        end else if (ar_to_db) begin
            db_full_q <= 1'b1;
        end else if (db_take) begin
            db_full_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            db_q <= 36'h0;
        end else if (ar_to_db) begin
            db_q <= ar_q;
        end
    end
endmodule

// file: hdl/ccs_top.sv
// Operation
// - full assembly register flags bit 0, moves to data bus or channel buffer
// - full channel buffer flags bit 1; read word leaves on channel strobe
// - termination raises channel inhibit, bit 3, blocking channel start requests
// - selected drive access error sets bit 10
// - channel data parity error recorded in bit 15
// - control word parity error sets bit 16 and terminates via inhibit
// - missing memory sets bit 17 and terminates via inhibit
// - wrong parity on read drive word sets bit 18
// - drive error during transfer latched into bit 19
// - bit 20 is OR of bits 15, 16, 17
// - write control word request, then bit 21 after channel stores it
// - overrun bit 22 on late write word or read words too fast
// - bit 23 is OR of data and control bus timeouts
// - bit 24 is OR of bits 9 and 10
// - low supply detection sets bit 25
// - new drive cycle before previous ends sets bit 28
// - control bits 29, 30 set interrupt enables, read back in status
// - busy only during transfers; done on any completion
// - priority level shown from bit 33
// - control bit 25 clears all error flags like bus reset
// - control bit 31 clears busy, sets done, releases channel, stops
`timescale 1ns/1ps
`include "ccs_map.svh"
module ccs_top (
    input wire logic CLK,
    input wire logic RST,
    input wire logic STATUS_RD,
    output ccs_pkg::ccs_word_t STATUS_WORD,
    input wire logic CONTROL_WR,
    input ccs_pkg::ccs_word_t CONTROL_WORD,
    input wire logic FUNC_WR,
    input ccs_pkg::ccs_func_t FUNC_CODE,
    input wire logic WRITE_MODE,
    input wire logic XFER_START,
    input wire logic XFER_END,
    input wire logic CHAN_WORD_STROBE,
    input ccs_pkg::ccs_word_t CHAN_DATA,
    output logic DEV_WORD_STROBE,
    output ccs_pkg::ccs_word_t DEV_DATA,
    output logic CHAN_START_REQ,
    output logic CHAN_INHIBIT,
    output logic WRITE_CW_REQ,
    input wire logic CW_STORED,
    input wire logic CHAN_DATA_PARITY,
    input wire logic CHAN_CW_PARITY,
    input wire logic CHAN_NXM,
    input wire logic CHAN_DONE,
    input wire logic DRIVE_LOAD,
    input wire logic [35:0] DRIVE_WORD,
    input wire logic DRIVE_PARITY,
    input wire logic DRIVE_SYNC,
    output logic DRIVE_WORD_VALID,
    output ccs_pkg::ccs_word_t DRIVE_OUT,
    input wire logic SEL_DRIVE_RAE,
    input wire logic DRIVE_EXC,
    input wire logic DB_TIMEOUT,
    input wire logic CB_TIMEOUT,
    input wire logic SUPPLY_LOW,
    input wire logic DIB_START,
    input wire logic DIB_END,
    output logic ACCESS_IRQ_EN,
    output logic ATTN_IRQ_EN,
    output ccs_pkg::ccs_pia_t IRQ_LEVEL
);
    import ccs_pkg::*;

    // ----------------------------------------
    // error flag indices
    // ----------------------------------------
    localparam int E_BADF = 0;
    localparam int E_SDRAE = 1;
    localparam int E_CHANNEL_DATA_PARITY_FAULT = 2;
    localparam int E_CTRL_WORD_PARITY_FAULT = 3;
    localparam int E_NXM = 4;
    localparam int E_DRIVE_BUS_PARITY_FAULT = 5;
    localparam int E_EXC = 6;
    localparam int E_OVR = 7;
    localparam int E_DBTO = 8;
    localparam int E_CBTO = 9;
    localparam int E_SUP = 10;
    localparam int E_CTRL_BUS_OVERRUN = 11;
    localparam int E_CWW = 12;

    ccs_err_if eb ();
    ccs_state_t state_q;
    logic busy_q;
    logic done_q;
    logic af_en_q;
    logic attention_irq_enable_q;
    ccs_pia_t pia_q;
    logic wcw_q;
    logic dib_busy_q;
    logic dev_strobe_q;
    logic ar_full;
    logic cb_full;
    logic db_full;
    ccs_word_t cb_word;
    logic ctl_stop;
    logic ctl_reset;
    logic active;
    logic chan_take;
    logic db_take;
    logic chan_fault;
    logic [12:0] eset;
    logic [12:0] eclr;

    function automatic logic ctl_bit(input ccs_word_t w, input int pos);
        ctl_bit = CONTROL_WR && w[pos];
    endfunction

    assign ctl_stop = ctl_bit(CONTROL_WORD, `CCS_CT_STOP);
    assign ctl_reset = ctl_bit(CONTROL_WORD, `CCS_CT_RESET);
    assign active = (state_q == CCS_XFER);
    assign chan_take = active && !WRITE_MODE && CHAN_WORD_STROBE && dev_strobe_q;
    assign db_take = active && WRITE_MODE && DRIVE_SYNC;
    assign chan_fault = eb.flags[E_CHANNEL_DATA_PARITY_FAULT] | eb.flags[E_CTRL_WORD_PARITY_FAULT] | eb.flags[E_NXM];

    ccs_err_bank u_err (
        .CLK(CLK),
        .RST(RST),
        .eb(eb)
    );

    ccs_path u_path (
        .CLK(CLK),
        .RST(RST),
        .write_mode(WRITE_MODE),
        .flush(state_q == CCS_IDLE),
        .chan_load(active && WRITE_MODE && CHAN_WORD_STROBE),
        .chan_word(CHAN_DATA),
        .chan_take(chan_take),
        .drive_load(active && DRIVE_LOAD),
        .drive_word(DRIVE_WORD),
        .db_take(db_take),
        .ar_full(ar_full),
        .cb_full(cb_full),
        .db_full(db_full),
        .cb_q(cb_word),
        .db_q(DRIVE_OUT)
    );

    // ----------------------------------------
    // error set and clear terms
    // ----------------------------------------
    always_comb begin
        eset = 13'h0;
        eset[E_BADF] = FUNC_WR && FUNC_CODE != `CCS_FUNC_READ
            && FUNC_CODE != `CCS_FUNC_WRITE;
        eset[E_SDRAE] = SEL_DRIVE_RAE;
        eset[E_CHANNEL_DATA_PARITY_FAULT] = CHAN_DATA_PARITY;
        eset[E_CTRL_WORD_PARITY_FAULT] = CHAN_CW_PARITY;
        eset[E_NXM] = CHAN_NXM;
        eset[E_DRIVE_BUS_PARITY_FAULT] = active && !WRITE_MODE && DRIVE_LOAD && !DRIVE_PARITY;
        eset[E_EXC] = active && DRIVE_EXC;
        // write: sync with nothing to send; read: drive word while assembly full
        eset[E_OVR] = active && ((WRITE_MODE && DRIVE_SYNC && !db_full)
            || (!WRITE_MODE && DRIVE_LOAD && ar_full));
        eset[E_DBTO] = DB_TIMEOUT;
        eset[E_CBTO] = CB_TIMEOUT;
        eset[E_SUP] = SUPPLY_LOW;
        eset[E_CTRL_BUS_OVERRUN] = DIB_START && dib_busy_q && !DIB_END;
        eset[E_CWW] = wcw_q && CW_STORED;
    end

    always_comb begin
        eclr = {13{ctl_reset}};
        eclr[E_DRIVE_BUS_PARITY_FAULT] = ctl_reset || ctl_bit(CONTROL_WORD, `CCS_CT_DRIVE_BUS_PARITY_FAULT_CLR);
        eclr[E_EXC] = ctl_reset || ctl_bit(CONTROL_WORD, `CCS_CT_EXC_CLR);
        eclr[E_CHANNEL_DATA_PARITY_FAULT] = ctl_reset || ctl_bit(CONTROL_WORD, `CCS_CT_CHAN_CLR);
        eclr[E_CTRL_WORD_PARITY_FAULT] = eclr[E_CHANNEL_DATA_PARITY_FAULT];
        eclr[E_NXM] = eclr[E_CHANNEL_DATA_PARITY_FAULT];
        eclr[E_OVR] = ctl_reset || ctl_bit(CONTROL_WORD, `CCS_CT_OVR_CLR);
        eclr[E_DBTO] = ctl_reset || ctl_bit(CONTROL_WORD, `CCS_CT_DRE_CLR);
        eclr[E_CBTO] = eclr[E_DBTO];
        eclr[E_BADF] = ctl_reset || ctl_bit(CONTROL_WORD, `CCS_CT_ILC_CLR);
        eclr[E_SDRAE] = eclr[E_BADF];
        eclr[E_CTRL_BUS_OVERRUN] = ctl_reset || ctl_bit(CONTROL_WORD, `CCS_CT_CTRL_BUS_OVERRUN_CLR);
        eclr[E_CWW] = ctl_reset || ctl_bit(CONTROL_WORD, `CCS_CT_WRT_CW);
    end

    assign eb.set = eset;
    assign eb.clr = eclr;

    // ----------------------------------------
    // transfer sequencer
    // ----------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            state_q <= CCS_IDLE;
        end else begin
            unique case (state_q)
                CCS_IDLE: begin
                    if (XFER_START && !ctl_stop) begin
                        state_q <= CCS_XFER;
                    end
                end
                CCS_XFER: begin
                    if (ctl_stop) begin
                        state_q <= CCS_DONE;
                    end else if (XFER_END || CHAN_DONE || CHAN_CW_PARITY || CHAN_NXM
                        || eb.flags[E_SUP] || eb.flags[E_OVR]) begin
                        state_q <= CCS_TERM;
                    end
                end
                CCS_TERM: begin
                    state_q <= CCS_DONE;
                end
                CCS_DONE: begin
                    state_q <= CCS_IDLE;
                end
                default: begin
                    state_q <= CCS_IDLE;
                end
            endcase
        end
    end

    // busy tracks transfers only; of register accesses only the stop bit (control bit 31) touches it, clearing it
    always_ff @(posedge CLK) begin
        if (RST) begin
            busy_q <= 1'b0;
        end else if (ctl_stop) begin
            busy_q <= 1'b0;
        end else if (state_q == CCS_IDLE && XFER_START) begin
            busy_q <= 1'b1;
        end else if (state_q == CCS_DONE) begin
            busy_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            done_q <= 1'b0;
        end else if (ctl_stop || (state_q == CCS_TERM)) begin
            done_q <= 1'b1;
        end else if (ctl_bit(CONTROL_WORD, `CCS_CT_DONE_CLR)) begin
            done_q <= 1'b0;
        end else if (state_q == CCS_IDLE && XFER_START) begin
            done_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // control write fields
    // ----------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            af_en_q <= 1'b0;
            attention_irq_enable_q <= 1'b0;
            pia_q <= `CCS_PIA_RESET;
        end else if (CONTROL_WR) begin
            af_en_q <= CONTROL_WORD[`CCS_CT_AF_EN];
            attention_irq_enable_q <= CONTROL_WORD[`CCS_CT_ATTENTION_IRQ_ENABLE];
            pia_q <= CONTROL_WORD[`CCS_CT_PIA +: 3];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            wcw_q <= 1'b0;
        end else if (ctl_bit(CONTROL_WORD, `CCS_CT_WRT_CW)) begin
            wcw_q <= 1'b1;
        end else if (CW_STORED) begin
            wcw_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            dib_busy_q <= 1'b0;
        end else if (DIB_START) begin
            dib_busy_q <= 1'b1;
        end else if (DIB_END) begin
            dib_busy_q <= 1'b0;
        end
    end

    // read handoff: strobe stays up until the channel answers or the sequencer leaves CCS_XFER
    always_ff @(posedge CLK) begin
        if (RST) begin
            dev_strobe_q <= 1'b0;
        end else if (!active || chan_take) begin
            dev_strobe_q <= 1'b0;
        end else if (!WRITE_MODE && cb_full) begin
            dev_strobe_q <= 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            DEV_DATA <= 36'h0;
        end else if (!WRITE_MODE && cb_full) begin
            DEV_DATA <= cb_word;
        end
    end

    assign DEV_WORD_STROBE = dev_strobe_q;
    assign CHAN_INHIBIT = (state_q == CCS_TERM) || (state_q == CCS_DONE);
    assign CHAN_START_REQ = active && !CHAN_INHIBIT;
    assign WRITE_CW_REQ = wcw_q;
    assign DRIVE_WORD_VALID = db_full;
    assign ACCESS_IRQ_EN = af_en_q;
    assign ATTN_IRQ_EN = attention_irq_enable_q;
    assign IRQ_LEVEL = pia_q;

    // ----------------------------------------
    // status word assembly
    // ----------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            STATUS_WORD <= 36'h0;
        end else begin
            STATUS_WORD <= 36'h0;
            STATUS_WORD[`CCS_ST_AR_FULL] <= ar_full;
            STATUS_WORD[`CCS_ST_CB_FULL] <= cb_full;
            STATUS_WORD[`CCS_ST_INHIBIT] <= CHAN_INHIBIT;
            STATUS_WORD[`CCS_ST_CHANNEL_ACTIVE_FLAG] <= active;
            STATUS_WORD[`CCS_ST_CHAN_STROBE] <= CHAN_WORD_STROBE;
            STATUS_WORD[`CCS_ST_BAD_FUNC] <= eb.flags[E_BADF];
            STATUS_WORD[`CCS_ST_SD_FAULT] <= eb.flags[E_SDRAE];
            STATUS_WORD[`CCS_ST_CHANNEL_DATA_PARITY_FAULT] <= eb.flags[E_CHANNEL_DATA_PARITY_FAULT];
            STATUS_WORD[`CCS_ST_CTRL_WORD_PARITY_FAULT] <= eb.flags[E_CTRL_WORD_PARITY_FAULT];
            STATUS_WORD[`CCS_ST_NXM] <= eb.flags[E_NXM];
            STATUS_WORD[`CCS_ST_DRIVE_BUS_PARITY_FAULT] <= eb.flags[E_DRIVE_BUS_PARITY_FAULT];
            STATUS_WORD[`CCS_ST_DRV_ERR] <= eb.flags[E_EXC];
            STATUS_WORD[`CCS_ST_CHAN_SUM] <= chan_fault;
            STATUS_WORD[`CCS_ST_CW_WRITTEN] <= eb.flags[E_CWW];
            STATUS_WORD[`CCS_ST_OVERRUN] <= eb.flags[E_OVR];
            STATUS_WORD[`CCS_ST_DRE] <= eb.flags[E_DBTO] | eb.flags[E_CBTO];
            STATUS_WORD[`CCS_ST_ILC] <= eb.flags[E_BADF] | eb.flags[E_SDRAE];
            STATUS_WORD[`CCS_ST_SUPPLY] <= eb.flags[E_SUP];
            STATUS_WORD[`CCS_ST_CTRL_BUS_OVERRUN] <= eb.flags[E_CTRL_BUS_OVERRUN];
            STATUS_WORD[`CCS_ST_AF_EN] <= af_en_q;
            STATUS_WORD[`CCS_ST_ATTENTION_IRQ_ENABLE] <= attention_irq_enable_q;
            STATUS_WORD[`CCS_ST_BUSY] <= busy_q;
            STATUS_WORD[`CCS_ST_DONE] <= done_q;
            STATUS_WORD[`CCS_ST_PIA +: 3] <= pia_q;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_stop;
        CONTROL_WR && CONTROL_WORD[`CCS_CT_STOP] && busy_q;
    endsequence
    sequence s_term_seen;
        !busy_q && done_q;
    endsequence
    property p_stop;
        @(posedge CLK) disable iff (RST) s_stop |=> s_term_seen;
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not end transfer");

    property p_badf;
        @(posedge CLK) disable iff (RST)
            (FUNC_WR && FUNC_CODE != 6'h39 && FUNC_CODE != 6'h31) |=> eb.flags[E_BADF];
    endproperty
    a_badf: assert property (p_badf) else $error("bad code not flagged");

    property p_sum;
        @(posedge CLK) disable iff (RST)
            ##1 STATUS_WORD[20] == $past(chan_fault);
    endproperty
    a_sum: assert property (p_sum) else $error("channel summary wrong");

    property p_ilc;
        @(posedge CLK) disable iff (RST)
            ##1 STATUS_WORD[24] == ($past(eb.flags[E_BADF]) | $past(eb.flags[E_SDRAE]));
    endproperty
    a_ilc: assert property (p_ilc) else $error("illegal command summary wrong");

    property p_reset_clr;
        @(posedge CLK) disable iff (RST)
            (ctl_reset && eset == 13'h0) |=> eb.flags == 13'h0;
    endproperty
    a_reset_clr: assert property (p_reset_clr) else $error("reset kept flags");

    property p_inh;
        @(posedge CLK) disable iff (RST) CHAN_INHIBIT |-> !CHAN_START_REQ;
    endproperty
    a_inh: assert property (p_inh) else $error("start while inhibited");

    property p_nxm;
        @(posedge CLK) disable iff (RST)
            (active && CHAN_NXM && !ctl_stop) |=> CHAN_INHIBIT ##1 done_q;
    endproperty
    a_nxm: assert property (p_nxm) else $error("missing memory did not terminate");

    property p_unused;
        @(posedge CLK) disable iff (RST)
            STATUS_WORD[2] == 1'b0 && STATUS_WORD[8:6] == 3'h0
            && STATUS_WORD[14:11] == 4'h0 && STATUS_WORD[27:26] == 2'h0;
    endproperty
    a_unused: assert property (p_unused) else $error("unused bit set");

    property p_supply;
        @(posedge CLK) disable iff (RST) SUPPLY_LOW |=> ##1 STATUS_WORD[25];
    endproperty
    a_supply: assert property (p_supply) else $error("supply low not shown");
endmodule

// file: dv/ccs_chan_model.sv
`timescale 1ns/1ps
module ccs_chan_model (
    input wire logic CLK,
    input wire logic RST,
    input wire logic DEV_WORD_STROBE,
    input wire logic WRITE_CW_REQ,
    output logic CHAN_WORD_STROBE,
    output logic CW_STORED
);
    // one answer per offered word, registered one cycle after the offer is seen
    always_ff @(posedge CLK) begin
        CHAN_WORD_STROBE <= !RST && DEV_WORD_STROBE && !CHAN_WORD_STROBE;
    end
    always_ff @(posedge CLK) begin
        CW_STORED <= !RST && WRITE_CW_REQ && !CW_STORED;
    end
endmodule

// file: dv/tb.sv
`timescale 1ns/1ps
module tb;
    import ccs_pkg::*;
    logic clk = 0, rst = 1, cwr = 0, fwr = 0, start = 0, xend = 0, dload = 0, dpar = 1, cdone = 0;
    ccs_word_t ctl = '0, st, dev_data, dword = '0;
    ccs_func_t fn = '0;
    logic [8:0] ev = '0;
    logic dstb, cstb, cwq, cwd, inh, req, aen, ten;
    ccs_pia_t lvl;
    int n_mismatch = 0, checked = 0, cyc = 0;
    ccs_top u_dut (.CLK(clk), .RST(rst), .STATUS_RD(1'b1), .STATUS_WORD(st),
        .CONTROL_WR(cwr), .CONTROL_WORD(ctl), .FUNC_WR(fwr), .FUNC_CODE(fn),
        .WRITE_MODE(1'b0), .XFER_START(start), .XFER_END(xend), .CHAN_WORD_STROBE(cstb),
        .CHAN_DATA(36'h0), .DEV_WORD_STROBE(dstb), .DEV_DATA(dev_data), .CHAN_START_REQ(req),
        .CHAN_INHIBIT(inh), .WRITE_CW_REQ(cwq), .CW_STORED(cwd), .CHAN_DATA_PARITY(ev[0]),
        .CHAN_CW_PARITY(ev[1]), .CHAN_NXM(ev[2]), .CHAN_DONE(cdone), .DRIVE_LOAD(dload),
        .DRIVE_WORD(dword), .DRIVE_PARITY(dpar), .DRIVE_SYNC(1'b0), .DRIVE_WORD_VALID(),
        .DRIVE_OUT(), .SEL_DRIVE_RAE(ev[3]), .DRIVE_EXC(ev[4]), .DB_TIMEOUT(ev[5]),
        .CB_TIMEOUT(ev[6]), .SUPPLY_LOW(ev[7]), .DIB_START(ev[8]), .DIB_END(1'b0),
        .ACCESS_IRQ_EN(aen), .ATTN_IRQ_EN(ten), .IRQ_LEVEL(lvl));
    ccs_chan_model u_chan (.CLK(clk), .RST(rst), .DEV_WORD_STROBE(dstb),
        .WRITE_CW_REQ(cwq), .CHAN_WORD_STROBE(cstb), .CW_STORED(cwd));
    initial begin
        forever #10 clk = ~clk;
    end
    function automatic ccs_word_t b(int i);
        return 36'h1 << i;
    endfunction
    // error flags plus every unused position, which must stay zero
    localparam ccs_word_t M = b(9) | b(10) | (36'h7ff << 15) | b(28) | b(2) | (36'h7 << 6)
        | (36'hf << 11) | (36'h3 << 26);
    localparam ccs_word_t XM = b(3) | b(4) | b(31) | b(32);
    localparam ccs_word_t MA = b(10) | (36'h7 << 15);
    localparam ccs_word_t MB = b(19) | b(25) | b(28);
    localparam ccs_word_t MS = b(20) | b(23) | b(24);
    task automatic cmp(string what, ccs_word_t exp, ccs_word_t got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic ctrl(ccs_word_t w);
        ctl <= w;
        cwr <= 1;
        tick(1);
        cwr <= 0;
        tick(4);
    endtask
    task automatic func(ccs_func_t c);
        fn <= c;
        fwr <= 1;
        tick(1);
        fwr <= 0;
        tick(3);
    endtask
    task automatic go();
        start <= 1;
        tick(1);
        start <= 0;
        tick(3);
    endtask
    task automatic t_func();
        func(6'ha);
        cmp("bad code", b(9) | b(24), st & M);
        ctrl(b(24));
        func(6'h39);
        func(6'h31);
        cmp("good codes", '0, st & M);
    endtask
    task automatic t_err();
        ccs_word_t tab [9];
        tab = '{b(15) | b(20), b(16) | b(20), b(17) | b(20), b(10) | b(24), b(19),
            b(23), b(23), b(25), b(28)};
        for (int i = 0; i < 9; i++) begin
            go();
            ev[i] <= 1;
            tick(1);
            ev <= '0;
            // overrun needs a second cycle start while the first is open
            if (i == 8) begin
                tick(1);
                ev[8] <= 1;
                tick(1);
                ev <= '0;
            end
            tick(3);
            cmp("error flags", tab[i], st & M);
            cmp("flag bits", tab[i] & MA, st & MA);
            cmp("flag bits", tab[i] & MB, st & MB);
            cmp("summaries", tab[i] & MS, st & MS);
            ctrl(b(25) | b(31));
            cmp("after reset bit", '0, st & M);
        end
    endtask
    task automatic t_ctl();
        ctrl(b(29) | b(30) | (36'h5 << 33));
        cmp("enables", b(29) | b(30) | (36'h5 << 33), st & (36'hee << 28));
        cmp("enable pins", {31'h0, 2'h3, 3'h5}, {31'h0, aen, ten, lvl});
        go();
        ctrl(b(31));
        cmp("stop", b(32), st & XM);
    endtask
    task automatic t_read();
        go();
        cmp("active", b(4) | b(31), st & XM);
        dword <= 36'h9a5c3e1d7;
        dload <= 1;
        tick(1);
        dload <= 0;
        for (int k = 0; k < 20 && cstb !== 1'b1; k++) tick(1);
        cmp("strobe answer", 36'h1, {35'h0, cstb});
        cmp("read word", dword, dev_data);
        dpar <= 0;
        dload <= 1;
        tick(1);
        dload <= 0;
        dpar <= 1;
        ctrl(b(21));
        tick(4);
        cmp("parity, cw", b(18) | b(21), st & (b(18) | b(21)));
        xend <= 1;
        tick(1);
        xend <= 0;
        for (int k = 0; k < 8 && inh !== 1'b1; k++) tick(1);
        cmp("inhibit", 36'h2, {34'h0, inh, req});
        tick(4);
        cmp("done", b(32), st & XM);
    endtask
    task automatic t_stops();
        go();
        cdone <= 1;
        tick(1);
        cdone <= 0;
        tick(4);
        cmp("chan done", b(32), st & XM);
        // second drive word while the assembly register is still full
        go();
        dload <= 1;
        tick(2);
        dload <= 0;
        tick(6);
        cmp("overrun", b(22) | b(32), st & (b(22) | XM));
    endtask
    task automatic complete_run();
        if (n_mismatch == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc > 4000) begin
            n_mismatch++;
            complete_run();
        end
    end
    initial begin
        tick(10);
        rst <= 0;
        tick(2);
        cmp("reset", '0, st);
        t_func();
        t_err();
        t_ctl();
        t_read();
        t_stops();
        complete_run();
    end
endmodule
